// ==== verilog/lpd_params.svh ====
// Offsets, field positions, reset values and timing counts of the loop DAC
`ifndef LPD_PARAMS_SVH
`define LPD_PARAMS_SVH

`define LPD_CMD_WR_DAC 8'h01
`define LPD_CMD_WR_CTRL 8'h02
`define LPD_CMD_FORCE_ALM 8'h06
`define LPD_CMD_RESET 8'h07
`define LPD_CMD_MEASURE 8'h08
`define LPD_CMD_NOP 8'h09
`define LPD_CMD_RD_DAC 8'h81
`define LPD_CMD_RD_CTRL 8'h82
`define LPD_CMD_RD_FAULT 8'h85

`define LPD_CTRL_PWR_BIT 7
`define LPD_CTRL_SEL_BIT 8
`define LPD_CTRL_RBDIS_BIT 11
`define LPD_CTRL_WDDIS_BIT 12
`define LPD_FLT_SPI_BIT 15
`define LPD_FLT_PEC_BIT 14

`define LPD_CTRL_RST 16'h0000
`define LPD_DAC_RST 16'h0000

`define LPD_FRAME_BITS 6'd24
`define LPD_FRAME_CRC_BITS 6'd32
`define LPD_CNT_SAT 6'd33
`define LPD_CRC_POLY 8'h07

`define LPD_CLK_PERIOD_NS 8
`define LPD_MS_NS 1000000
`define LPD_WDOG_TIMEOUT_MS 1000

`endif

// ==== verilog/lpd_pkg.sv ====
// Types shared by the loop DAC control and its serial receiver
`include "lpd_params.svh"
package lpd_pkg;

   typedef enum logic [1:0] {
      SPAN_4_20 = 2'h0,
      SPAN_3P8_21 = 2'h1,
      SPAN_3P2_24 = 2'h2
   } lpd_span_t;

   typedef enum logic [2:0] {
      VREG_1P8 = 3'h0, VREG_2P5 = 3'h1, VREG_3P0 = 3'h2, VREG_3P3 = 3'h3,
      VREG_5P0 = 3'h4, VREG_9P0 = 3'h5, VREG_12P0 = 3'h6, VREG_NONE = 3'h7
   } lpd_vreg_t;

   typedef enum logic [1:0] {
      ALM_NONE = 2'h0,
      ALM_3P2 = 2'h1,
      ALM_22P8 = 2'h2,
      ALM_24P0 = 2'h3
   } lpd_alm_t;

   // Gray order along idle -> power up -> convert
   typedef enum logic [1:0] {
      ADC_IDLE = 2'h0,
      ADC_PWR = 2'h1,
      ADC_CONV = 2'h3
   } lpd_adc_st_t;

   typedef struct packed {
      logic [7:0] cmd;
      logic [15:0] data;
   } lpd_frame_t;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic sclk_d;
      logic sync_d;
      logic [31:0] sh;
      logic [5:0] cnt;
      logic [23:0] tx;
      logic sdo;
      logic vld;
      logic crc_err;
      lpd_frame_t fr;
   } lpd_rx_t;

   typedef struct packed {
      logic [5:0] strap_s1;
      logic [5:0] strap_s2;
      logic [1:0] settle;
      logic straps_ok;
      lpd_span_t span;
      lpd_vreg_t vreg;
      logic vreg_ok;
      logic alarm_up;
      logic [15:0] dac;
      logic [15:0] ctrl;
      logic alarm;
      lpd_alm_t alm_lvl;
      logic spi_fault;
      logic pec_fault;
      logic [7:0] adc_res;
      lpd_adc_st_t adc_st;
      logic adc_start;
      logic [31:0] ms_cnt;
      logic [15:0] wd_cnt;
      logic [23:0] tx_word;
   } lpd_core_t;

   localparam lpd_core_t LPD_CORE_RST = '{
      strap_s1: 6'h00, strap_s2: 6'h00, settle: 2'h0, straps_ok: 1'b0,
      span: SPAN_4_20, vreg: VREG_1P8, vreg_ok: 1'b0, alarm_up: 1'b0,
      dac: `LPD_DAC_RST, ctrl: `LPD_CTRL_RST, alarm: 1'b1,
      alm_lvl: ALM_3P2, spi_fault: 1'b0, pec_fault: 1'b0, adc_res: 8'h00,
      adc_st: ADC_IDLE, adc_start: 1'b0, ms_cnt: 32'h0, wd_cnt: 16'h0,
      tx_word: 24'h000000};

endpackage

// ==== verilog/lpd_serial_rx.sv ====
// Serial command receiver: pin sync, 24/32-bit frames, check byte, readback
`timescale 1ns/100ps
`include "lpd_params.svh"
module lpd_serial_rx import lpd_pkg::*; (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic sclk_i,
   input wire logic sync_n_i,
   input wire logic sdin_i,
   input wire logic [23:0] tx_word_i,
   output logic sdo_o,
   output logic frame_vld_o,
   output logic crc_err_o,
   output lpd_frame_t frame_o
);

   lpd_rx_t q;
   lpd_rx_t n;
   logic sclk;
   logic syncn;
   logic din;
   logic sync_rise;
   logic crc_ok;

   // Edge detectors start at the idle pin levels so no false edge follows
   localparam lpd_rx_t RX_RST = '{s1: 3'h6, s2: 3'h6, sclk_d: 1'b1,
      sync_d: 1'b1, default: '0};

   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         if (c[7] ^ d[i]) begin
            c = {c[6:0], 1'b0} ^ `LPD_CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction

   assign sclk = q.s2[2];
   assign syncn = q.s2[1];
   assign din = q.s2[0];
   assign sync_rise = !q.sync_d && syncn;
   assign crc_ok = crc8(q.sh[31:8]) == q.sh[7:0];

   always_comb begin
      n = q;
      n.s1 = {sclk_i, sync_n_i, sdin_i};
      n.s2 = q.s1;
      n.sclk_d = sclk;
      n.sync_d = syncn;
      n.vld = 1'b0;
      n.crc_err = 1'b0;
      if (q.sync_d && !syncn) begin
         n.cnt = 6'd0;
         n.tx = tx_word_i;
         n.sdo = tx_word_i[23];
      end else if (!syncn) begin
         if (q.sclk_d && !sclk) begin
            n.sh = {q.sh[30:0], din};
            if (q.cnt != `LPD_CNT_SAT) begin
               n.cnt = q.cnt + 6'd1;
            end
         end else if (!q.sclk_d && sclk) begin
            n.tx = {q.tx[22:0], 1'b0};
            n.sdo = q.tx[22];
         end
      end
      // Any other length is dropped silently and does not feed the watchdog
      if (sync_rise) begin
         if (q.cnt == `LPD_FRAME_BITS) begin
            n.vld = 1'b1; // [RULE_15]
            n.fr = q.sh[23:0];
         end else if (q.cnt == `LPD_FRAME_CRC_BITS) begin
            n.vld = crc_ok; // [RULE_15]
            n.crc_err = !crc_ok;
            n.fr = q.sh[31:8];
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         q <= RX_RST;
      end else begin
         q <= n;
      end
   end

   assign sdo_o = q.sdo;
   assign frame_vld_o = q.vld;
   assign crc_err_o = q.crc_err;
   assign frame_o = q.fr;

   property p_frame_len;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      sync_rise && (q.cnt == `LPD_FRAME_BITS) |=>
         frame_vld_o && (frame_o == $past(q.sh[23:0]));
   endproperty
   a_p_frame_len: assert property (p_frame_len) // [RULE_15]
      else $error("24-bit frame not delivered");

   property p_frame_bad_len;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      frame_vld_o |-> $past(q.cnt == `LPD_FRAME_BITS ||
         q.cnt == `LPD_FRAME_CRC_BITS);
   endproperty
   a_p_frame_bad_len: assert property (p_frame_bad_len) // [RULE_15]
      else $error("frame accepted with wrong bit count");

endmodule

// ==== verilog/lpd_top.sv ====
// Loop DAC control: straps, power-on state, watchdog, measurement sequencing
// Overview of operation
// [RULE_01] Span straps pick 4-20, 3.8-21 or 3.2-24
// [RULE_02] Control bit 8 selects temperature or supply
// [RULE_03] Measure command powers converter, runs one conversion
// [RULE_04] Host sends measure only without auto readback
// [RULE_05] Fault register read returns latest conversion result
// [RULE_06] Host powers converter via bit 7 first
// [RULE_07] Power-on loads defaults, loop at alarm level
// [RULE_08] Alarm and defaults hold until host writes
// [RULE_09] Watchdog on from power-on, one second
// [RULE_10] No traffic in one second raises fault
// [RULE_11] Regulator straps decode seven voltages, 111 unused
// [RULE_12] Host ramps codes below 1.3 mA/ms
// [RULE_13] Alarm strap high upscale, low 3.2 mA
// [RULE_14] Watchdog timeout sets serial fault, forces alarm
// [RULE_15] Frame is command byte, data word, check
// [RULE_16] Straps sampled once after reset, then static
`timescale 1ns/100ps
`include "lpd_params.svh"
module lpd_top import lpd_pkg::*; #(
   parameter int unsigned MS_CYCLES = `LPD_MS_NS / `LPD_CLK_PERIOD_NS,
   parameter int unsigned WDOG_MS = `LPD_WDOG_TIMEOUT_MS
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic sclk_i,
   input wire logic sync_n_i,
   input wire logic sdin_i,
   output logic sdo_o,
   input wire logic span_strap_b0_i,
   input wire logic span_strap_b1_i,
   input wire logic alarm_dir_strap_i,
   input wire logic vreg_strap_b0_i,
   input wire logic vreg_strap_b1_i,
   input wire logic vreg_strap_b2_i,
   input wire logic adc_done_i,
   input wire logic [7:0] adc_data_i,
   output logic straps_ok_o,
   output lpd_span_t span_o,
   output lpd_vreg_t vreg_o,
   output logic vreg_ok_o,
   output logic [15:0] loop_code_o,
   output logic alarm_o,
   output lpd_alm_t alarm_level_o,
   output logic fault_o,
   output logic adc_power_o,
   output logic adc_sel_o,
   output logic adc_start_o
);

   lpd_core_t q;
   lpd_core_t n;
   logic frame_vld;
   logic crc_err;
   lpd_frame_t fr;
   logic ms_tick;
   logic wd_en;
   logic meas_req;
   logic [15:0] fault_word;

   function automatic lpd_span_t span_dec(input logic [1:0] s);
      case (s)
         2'h0: span_dec = SPAN_4_20;
         2'h2: span_dec = SPAN_3P2_24;
         default: span_dec = SPAN_3P8_21;
      endcase
   endfunction

   lpd_serial_rx u_rx (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .sclk_i(sclk_i),
      .sync_n_i(sync_n_i),
      .sdin_i(sdin_i),
      .tx_word_i(q.tx_word),
      .sdo_o(sdo_o),
      .frame_vld_o(frame_vld),
      .crc_err_o(crc_err),
      .frame_o(fr)
   );

   assign ms_tick = q.ms_cnt == 32'(MS_CYCLES - 1);
   assign wd_en = !q.ctrl[`LPD_CTRL_WDDIS_BIT];
   assign fault_word = {q.spi_fault, q.pec_fault, 6'h00, q.adc_res}; // [RULE_05]

   always_comb begin
      n = q;
      n.adc_start = 1'b0;
      meas_req = 1'b0;
      n.strap_s1 = {alarm_dir_strap_i, vreg_strap_b2_i, vreg_strap_b1_i,
         vreg_strap_b0_i, span_strap_b1_i, span_strap_b0_i};
      n.strap_s2 = q.strap_s1;
      // Straps are read once; later changes are ignored until next reset
      if (!q.straps_ok) begin
         if (q.settle == 2'h2) begin
            n.straps_ok = 1'b1; // [RULE_16]
            n.span = span_dec(q.strap_s2[1:0]); // [RULE_01]
            n.vreg = lpd_vreg_t'(q.strap_s2[4:2]); // [RULE_11]
            n.vreg_ok = q.strap_s2[4:2] != 3'h7; // [RULE_11]
            n.alarm_up = q.strap_s2[5]; // [RULE_13]
         end else begin
            n.settle = q.settle + 2'h1;
         end
      end
      // One-millisecond enable feeding the watchdog
      if (ms_tick || frame_vld) begin
         n.ms_cnt = 32'h0;
      end else begin
         n.ms_cnt = q.ms_cnt + 32'h1;
      end
      if (frame_vld) begin
         n.wd_cnt = 16'h0;
      end else if (ms_tick && wd_en && q.wd_cnt != 16'(WDOG_MS)) begin
         n.wd_cnt = q.wd_cnt + 16'h1; // [RULE_09]
      end
      if (frame_vld) begin
         if (!q.ctrl[`LPD_CTRL_RBDIS_BIT]) begin
            n.tx_word = {`LPD_CMD_RD_FAULT, fault_word}; // [RULE_05]
            meas_req = q.ctrl[`LPD_CTRL_PWR_BIT]; // [RULE_06]
         end
         case (fr.cmd)
            `LPD_CMD_WR_DAC: begin
               n.dac = fr.data;
               n.alarm = 1'b0; // [RULE_08]
            end
            `LPD_CMD_WR_CTRL: n.ctrl = fr.data;
            `LPD_CMD_FORCE_ALM: n.alarm = 1'b1;
            `LPD_CMD_RESET: begin
               n.dac = `LPD_DAC_RST;
               n.ctrl = `LPD_CTRL_RST;
               n.alarm = 1'b1;
            end
            `LPD_CMD_MEASURE: meas_req = 1'b1; // [RULE_03]
            `LPD_CMD_RD_DAC: n.tx_word = {fr.cmd, q.dac};
            `LPD_CMD_RD_CTRL: n.tx_word = {fr.cmd, q.ctrl};
            `LPD_CMD_RD_FAULT: begin
               n.tx_word = {fr.cmd, fault_word}; // [RULE_05]
               n.spi_fault = 1'b0;
               n.pec_fault = 1'b0;
            end
            default: n.tx_word = q.tx_word;
         endcase
      end
      // Setting the flags after their clear lets a same-cycle event win
      if (crc_err) begin
         n.pec_fault = 1'b1;
      end
      if (ms_tick && wd_en && !frame_vld &&
         q.wd_cnt == 16'(WDOG_MS - 1)) begin
         n.spi_fault = 1'b1; // [RULE_14]
         n.alarm = 1'b1; // [RULE_10]
      end
      // Requests while a conversion runs are dropped, not queued
      case (q.adc_st)
         ADC_IDLE: if (meas_req) n.adc_st = ADC_PWR; // [RULE_03]
         ADC_PWR: begin
            n.adc_start = 1'b1;
            n.adc_st = ADC_CONV;
         end
         ADC_CONV: if (adc_done_i) begin
            n.adc_res = adc_data_i; // [RULE_05]
            n.adc_st = ADC_IDLE;
         end
         default: n.adc_st = ADC_IDLE;
      endcase
      if (!n.alarm) begin
         n.alm_lvl = ALM_NONE;
      end else if (!n.alarm_up) begin
         n.alm_lvl = ALM_3P2; // [RULE_13]
      end else if (n.span == SPAN_3P2_24) begin
         n.alm_lvl = ALM_24P0; // [RULE_07]
      end else begin
         n.alm_lvl = ALM_22P8; // [RULE_07]
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         q <= LPD_CORE_RST; // [RULE_07]
      end else begin
         q <= n;
      end
   end

   assign straps_ok_o = q.straps_ok;
   assign span_o = q.span;
   assign vreg_o = q.vreg;
   assign vreg_ok_o = q.vreg_ok;
   assign loop_code_o = q.dac;
   assign alarm_o = q.alarm;
   assign alarm_level_o = q.alm_lvl;
   assign fault_o = q.spi_fault || q.pec_fault; // [RULE_10]
   assign adc_power_o = q.ctrl[`LPD_CTRL_PWR_BIT] || q.adc_st != ADC_IDLE;
   assign adc_sel_o = q.ctrl[`LPD_CTRL_SEL_BIT]; // [RULE_02]
   assign adc_start_o = q.adc_start;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   property p_span;
      !q.straps_ok && q.settle == 2'h2 |=>
         span_o == span_dec($past(q.strap_s2[1:0])) && straps_ok_o;
   endproperty
   a_p_span: assert property (p_span) // [RULE_01]
      else $error("span strap decode wrong");

   property p_vreg;
      !q.straps_ok && q.settle == 2'h2 |=>
         vreg_ok_o == ($past(q.strap_s2[4:2]) != 3'h7);
   endproperty
   a_p_vreg: assert property (p_vreg) // [RULE_11]
      else $error("regulator strap decode wrong");

   property p_static;
      straps_ok_o |=> $stable(span_o) && $stable(vreg_o) && straps_ok_o;
   endproperty
   a_p_static: assert property (p_static) // [RULE_16]
      else $error("strap decode changed after capture");

   property p_sel;
      frame_vld && fr.cmd == `LPD_CMD_WR_CTRL |=>
         adc_sel_o == $past(fr.data[8]);
   endproperty
   a_p_sel: assert property (p_sel) // [RULE_02]
      else $error("input select not taken from control bit");

   property p_meas;
      frame_vld && fr.cmd == `LPD_CMD_MEASURE && q.adc_st == ADC_IDLE |->
         ##1 adc_power_o ##1 adc_start_o && adc_power_o;
   endproperty
   a_p_meas: assert property (p_meas) // [RULE_03]
      else $error("measure command did not start conversion");

   property p_result;
      q.adc_st == ADC_CONV && adc_done_i |=>
         fault_word[7:0] == $past(adc_data_i);
   endproperty
   a_p_result: assert property (p_result) // [RULE_05]
      else $error("conversion result not in fault word");

   property p_por;
      $rose(nrst_i) |-> alarm_o && loop_code_o == `LPD_DAC_RST &&
         !q.ctrl[`LPD_CTRL_WDDIS_BIT];
   endproperty
   a_p_por: assert property (p_por) // [RULE_07]
      else $error("power-on state wrong");

   property p_hold;
      alarm_o && !(frame_vld && fr.cmd == `LPD_CMD_WR_DAC) |=> alarm_o;
   endproperty
   a_p_hold: assert property (p_hold) // [RULE_08]
      else $error("alarm left without a code write");

   property p_wdog;
      ms_tick && wd_en && !frame_vld && q.wd_cnt == 16'(WDOG_MS - 1) |=>
         fault_o && alarm_o && q.spi_fault;
   endproperty
   a_p_wdog: assert property (p_wdog) // [RULE_14]
      else $error("watchdog timeout did not raise fault");

   property p_alm_dn;
      alarm_o && straps_ok_o && !q.alarm_up |-> alarm_level_o == ALM_3P2;
   endproperty
   a_p_alm_dn: assert property (p_alm_dn) // [RULE_13]
      else $error("downscale alarm level wrong");

   c_meas: cover property (adc_start_o ##[1:50] adc_done_i);
   c_wdog: cover property ($rose(q.spi_fault));
   c_clear: cover property (alarm_o ##1 !alarm_o);
   c_crc: cover property (crc_err);

endmodule

// ==== tb/lpd_host_model.sv ====
// Host side of the serial command link, one frame per call
`timescale 1ns/100ps
module lpd_host_model (
   input wire logic ref_clk_i,
   output logic sclk_o,
   output logic sync_n_o,
   output logic sdin_o,
   input wire logic sdo_i
);
   // Clock idles high and stands still between frames
   initial begin
      sclk_o = 1'b1;
      sync_n_o = 1'b1;
      sdin_o = 1'b0;
   end
   function automatic logic [7:0] crc8(input logic [23:0] w);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
      end
      return c;
   endfunction
   // Bits go out MSB first, sampled by the device on the falling edge
   task automatic xfer(input logic [31:0] w, input int n,
      output logic [23:0] rd);
      rd = 24'h000000;
      @(posedge ref_clk_i);
      sync_n_o <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sdin_o <= w[i];
         repeat (5) @(posedge ref_clk_i);
         sclk_o <= 1'b0;
         rd = {rd[22:0], sdo_i};
         repeat (10) @(posedge ref_clk_i);
         sclk_o <= 1'b1;
         repeat (5) @(posedge ref_clk_i);
      end
      sync_n_o <= 1'b1;
      // Released line must not keep showing the last bit
      sdin_o <= ~sdin_o;
      repeat (8) @(posedge ref_clk_i);
   endtask
endmodule

// ==== tb/test_lpd_top.sv ====
// Self-checking bench of the loop DAC control
`timescale 1ns/100ps
module test_lpd_top import lpd_pkg::*; ;
   logic clk, nrst, sclk, sync_n, sdin, sdo, sp0, sp1, adir, vr0, vr1, vr2;
   logic adc_done, straps_ok, vreg_ok, alarm, fault, apwr, asel, astart;
   logic [7:0] adc_data, res;
   logic [15:0] code, d;
   logic [23:0] rd;
   logic [3:0] adc_cnt = 4'h0;
   lpd_span_t span;
   lpd_vreg_t vreg;
   lpd_alm_t alm;
   int num_errors = 0, checked = 0, cycles = 0, starts = 0, prev, seed;

   lpd_top #(.MS_CYCLES(100), .WDOG_MS(10)) u_lpd_top (
      .ref_clk_i(clk), .nrst_i(nrst), .sclk_i(sclk), .sync_n_i(sync_n),
      .sdin_i(sdin), .sdo_o(sdo), .span_strap_b0_i(sp0),
      .span_strap_b1_i(sp1), .alarm_dir_strap_i(adir),
      .vreg_strap_b0_i(vr0), .vreg_strap_b1_i(vr1), .vreg_strap_b2_i(vr2),
      .adc_done_i(adc_done), .adc_data_i(adc_data),
      .straps_ok_o(straps_ok), .span_o(span), .vreg_o(vreg),
      .vreg_ok_o(vreg_ok), .loop_code_o(code), .alarm_o(alarm),
      .alarm_level_o(alm), .fault_o(fault), .adc_power_o(apwr),
      .adc_sel_o(asel), .adc_start_o(astart));

   lpd_host_model u_lpd_host_model (.ref_clk_i(clk), .sclk_o(sclk),
      .sync_n_o(sync_n), .sdin_o(sdin), .sdo_i(sdo));

   initial clk = 1'b0;
   always #4 clk = ~clk;

   // Converter answers six cycles after each start pulse
   always @(posedge clk) begin
      adc_done <= (adc_cnt == 4'h1);
      if (astart === 1'b1) begin
         adc_cnt <= 4'h6;
         starts <= starts + 1;
      end else if (adc_cnt != 4'h0) begin
         adc_cnt <= adc_cnt - 4'h1;
      end
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         num_errors = num_errors + 1;
         final_report();
      end
   end

   task automatic final_report();
      if (num_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, exp, input string m);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   function automatic lpd_span_t exp_span(input logic b1, b0);
      if ({b1, b0} == 2'b10) return SPAN_3P2_24;
      return ({b1, b0} == 2'b00) ? SPAN_4_20 : SPAN_3P8_21;
   endfunction

   function automatic lpd_alm_t exp_alm(input logic dir, lpd_span_t s);
      if (!dir) return ALM_3P2;
      return (s == SPAN_3P2_24) ? ALM_24P0 : ALM_22P8;
   endfunction

   task automatic do_reset(input logic [5:0] s);
      {adir, sp1, sp0, vr2, vr1, vr0} <= s;
      nrst <= 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
   endtask

   task automatic fr(input logic [7:0] c, input logic [15:0] v);
      u_lpd_host_model.xfer({8'h00, c, v}, 24, rd);
   endtask

   initial begin
      seed = 32'h16554926;
      nrst = 1'b0;
      {adir, sp1, sp0, vr2, vr1, vr0} = 6'h00;
      adc_data = 8'h00;
      // Codes 0 to 7 on both 3-bit strap groups alike, then random ones
      for (int i = 0; i < 12; i++) begin
         do_reset((i < 8) ? {i[2:0], i[2:0]} : 6'($random(seed)));
         chk(straps_ok, 1'b1, "straps");
         chk(span, exp_span(sp1, sp0), "span");
         chk(vreg, {vr2, vr1, vr0}, "vreg");
         chk(vreg_ok, ~&{vr2, vr1, vr0}, "vreg ok");
         chk(alm, exp_alm(adir, exp_span(sp1, sp0)), "alarm lvl");
         chk({alarm, fault, code}, {2'b10, 16'h0}, "power-on");
      end
      // Silence until the watchdog runs out
      repeat (880) @(posedge clk);
      chk({fault, alarm, code}, {2'b01, 16'h0}, "hold");
      repeat (240) @(posedge clk);
      chk({fault, alarm}, 2'b11, "timeout");
      // Readback on demand, watchdog off, then clear the flags
      fr(8'h02, 16'h1800);
      fr(8'h85, 16'h0000);
      chk(fault, 1'b0, "clear");
      for (int s = 0; s < 2; s++) begin
         fr(8'h02, 16'h1800 | 16'(s << 8));
         chk(asel, s[0], "select");
         res = 8'($random(seed));
         adc_data <= res;
         prev = starts;
         fr(8'h08, 16'h0000);
         repeat (10) @(posedge clk);
         chk(24'(starts), 24'(prev + 1), "measure");
         fr(8'h85, 16'h0000);
         fr(8'h09, 16'h0000);
         chk(rd, {8'h85, 8'h00, res}, "result");
      end
      // Small ramp steps first, then random codes
      for (int i = 0; i < 6; i++) begin
         d = (i < 4) ? 16'h4000 + 16'(i * 256) : 16'($random(seed));
         fr(8'h01, d);
         chk({alarm, code}, {1'b0, d}, "dac write");
      end
      d = 16'($random(seed));
      u_lpd_host_model.xfer({8'h01, d, u_lpd_host_model.crc8({8'h01, d})},
         32, rd);
      chk(code, d, "checked frame");
      u_lpd_host_model.xfer({8'h01, ~d, ~u_lpd_host_model.crc8({8'h01, ~d})},
         32, rd);
      chk({fault, code}, {1'b1, d}, "bad check");
      u_lpd_host_model.xfer({9'h003, ~d}, 23, rd);
      chk(code, d, "short frame");
      // Auto readback needs the converter powered first
      fr(8'h02, 16'h1080);
      chk(apwr, 1'b1, "power bit");
      prev = starts;
      fr(8'h09, 16'h0000);
      repeat (10) @(posedge clk);
      chk(24'(starts), 24'(prev + 1), "auto conv");
      // Register reads with auto readback off; word shows one frame later
      fr(8'h02, 16'h1800);
      fr(8'h81, 16'h0000);
      fr(8'h82, 16'h0000);
      chk(rd, {8'h81, d}, "dac read");
      fr(8'h09, 16'h0000);
      chk(rd, {8'h82, 16'h1800}, "ctrl read");
      fr(8'h06, 16'h0000);
      chk(alarm, 1'b1, "forced alarm");
      chk(alm, exp_alm(adir, exp_span(sp1, sp0)), "forced lvl");
      fr(8'h07, 16'h0000);
      chk({alarm, code}, {1'b1, 16'h0000}, "reg reset");
      final_report();
   end
endmodule
